// ### io_proc_fetch_block_move.sv
// Instruction fetch and block move sequencer of the I/O processor
`timescale 1ns/1ps
`default_nettype none
`include "io_fetch_consts.svh"
module io_proc_fetch_block_move
	import io_fetch_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pp_wr,
	input wire logic [31:0] pp_wdata,
	input wire logic irq_serviced,
	input wire logic source_io_space_select,
	input wire logic dest_io_space_select,
	input wire logic [1:0] burst_size_sel,
	input wire logic fifo_ready,
	input wire logic fetch_ack,
	input wire logic fetch_err,
	input wire logic [31:0] fetch_data,
	input wire logic bus_gnt_n,
	input wire logic burst_done,
	input wire logic bus_err,
	output logic fetch_req,
	output logic [31:0] fetch_addr,
	output logic fetch_ram_sel,
	output logic bus_req_n,
	output logic burst_active,
	output logic [31:0] burst_addr,
	output logic [7:0] burst_len,
	output logic burst_to_mem,
	output logic burst_io_space,
	output logic host_irq,
	output logic halted,
	output logic [1:0] irq_cause,
	output logic [31:0] program_ptr,
	output logic [7:0] opcode_reg,
	output logic [23:0] transfer_count_reg,
	output logic [31:0] second_word_reg,
	output logic [31:0] next_data_address_reg,
	output logic [31:0] temp_shadow_reg
);
	seq_state_t state_ff, nxt_state;
	irq_cause_t cause_ff, nxt_cause;
	logic req_ff, nxt_req;
	logic [31:0] faddr_ff, nxt_faddr;
	logic ram_ff, nxt_ram;
	logic breq_n_ff, nxt_breq_n;
	logic bact_ff, nxt_bact;
	logic [31:0] baddr_ff, nxt_baddr;
	logic [7:0] blen_ff, nxt_blen;
	logic tomem_ff, nxt_tomem;
	logic bio_ff, nxt_bio;
	logic irq_ff, nxt_irq;
	logic halt_ff, nxt_halt;
	logic [31:0] pp_ff, nxt_pp;
	logic [7:0] opc_ff, nxt_opc;
	logic [23:0] cnt_ff, nxt_cnt;
	logic [31:0] sw_ff, nxt_sw;
	logic [31:0] nda_ff, nxt_nda;
	logic [31:0] tmp_ff, nxt_tmp;
	logic gnt_n_s;
	logic d_move, d_int, d_mem, d_ind, d_tbl, d_tomem, d_ill;
	logic [23:0] rest;

	function automatic logic [7:0] burst_bytes(input logic [1:0] sel, input logic [23:0] cnt);
		logic [7:0] full;
		full = `BURST_UNIT << sel;
		burst_bytes = (cnt < {16'h0000, full}) ? cnt[7:0] : full;
	endfunction : burst_bytes

	function automatic logic in_ram(input logic [31:0] a);
		in_ram = ((a & `RAM_MASK) == `RAM_BASE);
	endfunction : in_ram

	sync2 u_gnt_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(bus_gnt_n),
		.dout(gnt_n_s)
	);

	// The latched first word is decoded while the second word arrives
	instr_decode u_dec (
		.word({opc_ff, cnt_ff}),
		.is_move(d_move),
		.is_int(d_int),
		.is_memmove(d_mem),
		.indirect(d_ind),
		.table_ind(d_tbl),
		.to_mem(d_tomem),
		.illegal(d_ill)
	);

	assign rest = cnt_ff - {16'h0000, blen_ff};

	always_comb begin
		nxt_state = state_ff;
		nxt_cause = cause_ff;
		nxt_req = req_ff;
		nxt_faddr = faddr_ff;
		nxt_ram = ram_ff;
		nxt_breq_n = breq_n_ff;
		nxt_bact = bact_ff;
		nxt_baddr = baddr_ff;
		nxt_blen = blen_ff;
		nxt_tomem = tomem_ff;
		nxt_bio = bio_ff;
		nxt_irq = irq_ff;
		nxt_pp = pp_ff;
		nxt_opc = opc_ff;
		nxt_cnt = cnt_ff;
		nxt_sw = sw_ff;
		nxt_nda = nda_ff;
		nxt_tmp = tmp_ff;
		case (state_ff)
			ST_IDLE, ST_HALT: begin
				if (irq_serviced) begin
					nxt_irq = 1'h0;
				end
				// A pointer write while the interrupt is still pending is ignored
				if (pp_wr && !irq_ff) begin
					nxt_cause = CAUSE_NONE;
					if (pp_wdata[`ALIGN_HI:0] != `ALIGN_ZERO) begin
						nxt_irq = 1'h1;
						nxt_cause = CAUSE_ILLEGAL;
						nxt_state = ST_HALT;
					end else begin
						nxt_pp = pp_wdata;
						nxt_faddr = pp_wdata;
						nxt_ram = in_ram(pp_wdata);
						nxt_req = 1'h1;
						nxt_state = ST_F1;
					end
				end
			end
			ST_F1: begin
				if (fetch_err) begin
					nxt_req = 1'h0;
					nxt_irq = 1'h1;
					nxt_cause = CAUSE_ERR;
					nxt_state = ST_HALT;
				end else if (fetch_ack) begin
					nxt_opc = fetch_data[`OPC_HI:`OPC_LO];
					nxt_cnt = fetch_data[`CNT_HI:0];
					nxt_faddr = faddr_ff + `WORD_STEP;
					nxt_state = ST_F2;
				end
			end
			ST_F2: begin
				if (fetch_err) begin
					nxt_req = 1'h0;
					nxt_irq = 1'h1;
					nxt_cause = CAUSE_ERR;
					nxt_state = ST_HALT;
				end else if (fetch_ack) begin
					nxt_sw = fetch_data;
					nxt_pp = pp_ff + (d_mem ? `LEN_LONG : `LEN_SHORT);
					nxt_tomem = d_tomem;
					nxt_bio = d_tomem ? dest_io_space_select : source_io_space_select;
					if (d_mem) begin
						nxt_faddr = faddr_ff + `WORD_STEP;
						nxt_state = ST_F3;
					end else if (d_int || d_ill) begin
						nxt_req = 1'h0;
						nxt_irq = 1'h1;
						nxt_cause = d_int ? CAUSE_INT : CAUSE_ILLEGAL;
						nxt_state = ST_HALT;
					end else if (d_ind) begin
						nxt_faddr = fetch_data;
						nxt_ram = in_ram(fetch_data);
						nxt_state = ST_FIND;
					end else begin
						nxt_nda = fetch_data;
						nxt_req = 1'h0;
						nxt_state = ST_WAIT;
					end
				end
			end
			ST_F3: begin
				nxt_req = !(fetch_ack || fetch_err);
				if (fetch_ack || fetch_err) begin
					nxt_tmp = fetch_data;
					// Memory-to-memory copies are not carried out by this sequencer
					nxt_irq = 1'h1;
					nxt_cause = fetch_err ? CAUSE_ERR : CAUSE_ILLEGAL;
					nxt_state = ST_HALT;
				end
			end
			ST_FIND: begin
				nxt_req = !(fetch_ack || fetch_err);
				if (fetch_err) begin
					nxt_irq = 1'h1;
					nxt_cause = CAUSE_ERR;
					nxt_state = ST_HALT;
				end else if (fetch_ack) begin
					nxt_nda = fetch_data;
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (cnt_ff == `COUNT_ZERO) begin
					nxt_faddr = pp_ff;
					nxt_ram = in_ram(pp_ff);
					nxt_req = 1'h1;
					nxt_state = ST_F1;
				end else if (fifo_ready) begin
					nxt_breq_n = 1'h0;
					nxt_state = ST_REQ;
				end
			end
			ST_REQ: begin
				if (!gnt_n_s) begin
					nxt_bact = 1'h1;
					nxt_baddr = nda_ff;
					nxt_blen = burst_bytes(burst_size_sel, cnt_ff);
					nxt_state = ST_BURST;
				end
			end
			ST_BURST: begin
				if (burst_done) begin
					nxt_bact = 1'h0;
					nxt_breq_n = 1'h1;
					nxt_cnt = rest;
					nxt_nda = nda_ff + {24'h000000, blen_ff};
					if (bus_err) begin
						nxt_irq = 1'h1;
						nxt_cause = CAUSE_ERR;
						nxt_state = ST_HALT;
					end else begin
						// Zero count is picked up in the wait state to refetch
						nxt_state = ST_WAIT;
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		// Registered so the halt output comes straight from a flop
		nxt_halt = (nxt_state == ST_HALT);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cause_ff <= CAUSE_NONE;
			req_ff <= 1'h0;
			faddr_ff <= 32'h00000000;
			ram_ff <= 1'h0;
			breq_n_ff <= 1'h1;
			bact_ff <= 1'h0;
			baddr_ff <= 32'h00000000;
			blen_ff <= 8'h00;
			tomem_ff <= 1'h0;
			bio_ff <= 1'h0;
			irq_ff <= 1'h0;
			halt_ff <= 1'h0;
			pp_ff <= 32'h00000000;
			opc_ff <= 8'h00;
			cnt_ff <= 24'h000000;
			sw_ff <= 32'h00000000;
			nda_ff <= 32'h00000000;
			tmp_ff <= 32'h00000000;
		end else begin
			state_ff <= nxt_state;
			cause_ff <= nxt_cause;
			req_ff <= nxt_req;
			faddr_ff <= nxt_faddr;
			ram_ff <= nxt_ram;
			breq_n_ff <= nxt_breq_n;
			bact_ff <= nxt_bact;
			baddr_ff <= nxt_baddr;
			blen_ff <= nxt_blen;
			tomem_ff <= nxt_tomem;
			bio_ff <= nxt_bio;
			irq_ff <= nxt_irq;
			halt_ff <= nxt_halt;
			pp_ff <= nxt_pp;
			opc_ff <= nxt_opc;
			cnt_ff <= nxt_cnt;
			sw_ff <= nxt_sw;
			nda_ff <= nxt_nda;
			tmp_ff <= nxt_tmp;
		end
	end

	assign fetch_req = req_ff;
	assign fetch_addr = faddr_ff;
	assign fetch_ram_sel = ram_ff;
	assign bus_req_n = breq_n_ff;
	assign burst_active = bact_ff;
	assign burst_addr = baddr_ff;
	assign burst_len = blen_ff;
	assign burst_to_mem = tomem_ff;
	assign burst_io_space = bio_ff;
	assign host_irq = irq_ff;
	assign halted = halt_ff;
	assign irq_cause = cause_ff;
	assign program_ptr = pp_ff;
	assign opcode_reg = opc_ff;
	assign transfer_count_reg = cnt_ff;
	assign second_word_reg = sw_ff;
	assign next_data_address_reg = nda_ff;
	assign temp_shadow_reg = tmp_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_word1;
		state_ff == ST_F1 && fetch_ack && !fetch_err;
	endsequence
	sequence s_word2;
		state_ff == ST_F2 && fetch_ack && !fetch_err;
	endsequence

	property p_irq_halts;
		$rose(irq_ff) |-> halt_ff && state_ff == ST_HALT && cause_ff != CAUSE_NONE;
	endproperty
	a_irq_halts: assert property (p_irq_halts) else $error("irq without halt");
	property p_stay_halted;
		state_ff == ST_HALT && irq_ff |=> state_ff == ST_HALT && !req_ff && breq_n_ff;
	endproperty
	a_stay_halted: assert property (p_stay_halted) else $error("left halt early");
	property p_restart;
		(state_ff == ST_HALT || state_ff == ST_IDLE) && pp_wr && !irq_ff
			&& pp_wdata[`ALIGN_HI:0] == `ALIGN_ZERO
			|=> req_ff && faddr_ff == $past(pp_wdata) && pp_ff == $past(pp_wdata)
			&& ram_ff == in_ram($past(pp_wdata));
	endproperty
	a_restart: assert property (p_restart) else $error("pointer write did not fetch");
	property p_word_load;
		s_word2 |=> sw_ff == $past(fetch_data) && opc_ff == $past(opc_ff);
	endproperty
	a_word_load: assert property (p_word_load) else $error("word two not loaded");
	property p_opcode;
		s_word1 |=> opc_ff == $past(fetch_data[`OPC_HI:`OPC_LO])
			&& cnt_ff == $past(fetch_data[`CNT_HI:0]);
	endproperty
	a_opcode: assert property (p_opcode) else $error("opcode or count wrong");
	property p_aligned;
		req_ff && state_ff != ST_FIND |-> faddr_ff[`ALIGN_HI:0] == `ALIGN_ZERO;
	endproperty
	a_aligned: assert property (p_aligned) else $error("misaligned fetch");
	property p_pp_step;
		s_word2 ##0 !d_mem |=> pp_ff == $past(pp_ff) + `LEN_SHORT;
	endproperty
	a_pp_step: assert property (p_pp_step) else $error("pointer not advanced");
	property p_pp_long;
		s_word2 ##0 d_mem |=> pp_ff == $past(pp_ff) + `LEN_LONG && state_ff == ST_F3 && req_ff;
	endproperty
	a_pp_long: assert property (p_pp_long) else $error("long instruction step wrong");
	property p_indirect;
		s_word2 ##0 (d_move && d_ind && !d_tbl)
			|=> state_ff == ST_FIND && req_ff && faddr_ff == $past(fetch_data);
	endproperty
	a_indirect: assert property (p_indirect) else $error("no pointer fetch");
	property p_direct;
		s_word2 ##0 (d_move && !d_ind && !d_tbl)
			|=> state_ff == ST_WAIT && nda_ff == $past(fetch_data);
	endproperty
	a_direct: assert property (p_direct) else $error("address not loaded");

	property p_fifo_gate;
		$fell(breq_n_ff) |-> $past(fifo_ready) && $past(state_ff) == ST_WAIT;
	endproperty
	a_fifo_gate: assert property (p_fifo_gate) else $error("bus asked before fifo ready");

	property p_burst_end;
		state_ff == ST_BURST && burst_done
			|=> breq_n_ff && !bact_ff && cnt_ff == $past(rest)
			&& nda_ff == $past(nda_ff) + {24'h000000, $past(blen_ff)};
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("burst bookkeeping wrong");

	property p_refetch;
		state_ff == ST_BURST && burst_done && !bus_err && rest == `COUNT_ZERO
			|=> ##1 req_ff && faddr_ff == pp_ff && state_ff == ST_F1;
	endproperty
	a_refetch: assert property (p_refetch) else $error("no fetch after move");

	property p_space;
		bact_ff |-> bio_ff == (tomem_ff ? dest_io_space_select : source_io_space_select);
	endproperty
	a_space: assert property (p_space) else $error("space select wrong");

endmodule : io_proc_fetch_block_move
`default_nettype wire

// ### io_fetch_consts.svh
// Constant definitions for the instruction fetch and block move sequencer
`ifndef IO_FETCH_CONSTS_SVH
`define IO_FETCH_CONSTS_SVH
`define TYPE_HI 31
`define TYPE_LO 30
`define IND_BIT 29
`define TBL_BIT 28
`define DIR_BIT 24
`define OPC_HI 31
`define OPC_LO 24
`define CNT_HI 23
`define SUB_HI 29
`define SUB_LO 27
`define TYPE_MOVE 2'h0
`define TYPE_XFER 2'h2
`define TYPE_MEMMOVE 2'h3
`define SUB_INT 3'h3
`define ALIGN_HI 1
`define ALIGN_ZERO 2'h0
`define WORD_STEP 32'h4
`define LEN_SHORT 32'h8
`define LEN_LONG 32'hC
`define RAM_MASK 32'hFFFFF000
`define RAM_BASE 32'hFFFFF000
`define BURST_UNIT 8'h04
`define COUNT_ZERO 24'h000000
`endif

// ### io_fetch_pkg.sv
// Types shared by the fetch sequencer modules
package io_fetch_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_F1 = 4'h1,
		ST_F2 = 4'h2,
		ST_F3 = 4'h3,
		ST_FIND = 4'h4,
		ST_WAIT = 4'h5,
		ST_REQ = 4'h6,
		ST_BURST = 4'h7,
		ST_HALT = 4'h8
	} seq_state_t;
	typedef enum logic [1:0] {
		CAUSE_NONE = 2'h0,
		CAUSE_INT = 2'h1,
		CAUSE_ERR = 2'h2,
		CAUSE_ILLEGAL = 2'h3
	} irq_cause_t;
endpackage : io_fetch_pkg

// ### sync2.sv
// Two flip-flop synchroniser for a level from a pin
`timescale 1ns/1ps
`default_nettype none
module sync2 (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic meta_ff;
	logic hold_ff;
	logic nxt_meta;
	logic nxt_hold;
	always_comb begin
		nxt_meta = din;
		nxt_hold = meta_ff;
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_ff <= 1'h1;
			hold_ff <= 1'h1;
		end else begin
			meta_ff <= nxt_meta;
			hold_ff <= nxt_hold;
		end
	end
	assign dout = hold_ff;
endmodule : sync2
`default_nettype wire

// ### instr_decode.sv
// Decoder for the first instruction word
`timescale 1ns/1ps
`default_nettype none
`include "io_fetch_consts.svh"
module instr_decode (
	input wire logic [31:0] word,
	output logic is_move,
	output logic is_int,
	output logic is_memmove,
	output logic indirect,
	output logic table_ind,
	output logic to_mem,
	output logic illegal
);
	always_comb begin
		is_move = (word[`TYPE_HI:`TYPE_LO] == `TYPE_MOVE);
		is_int = (word[`TYPE_HI:`TYPE_LO] == `TYPE_XFER) && (word[`SUB_HI:`SUB_LO] == `SUB_INT);
		is_memmove = (word[`TYPE_HI:`TYPE_LO] == `TYPE_MEMMOVE);
		indirect = word[`IND_BIT];
		table_ind = word[`TBL_BIT];
		// Data in phase moves bytes off the link into memory
		to_mem = word[`DIR_BIT];
		// Table-relative addressing is not handled here, so it halts like any unknown
		illegal = !(is_int || is_memmove || (is_move && !table_ind));
	end
endmodule : instr_decode
`default_nettype wire

// ### bus_mem_model.sv
// Memory and bus arbiter model on the far side of the fetch sequencer
`timescale 1ns/1ps
`default_nettype none
module bus_mem_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	input wire logic bus_req_n,
	input wire logic burst_active,
	input wire logic inj_ferr,
	input wire logic inj_berr,
	input wire logic [3:0] lag,
	output logic fetch_ack,
	output logic fetch_err,
	output logic [31:0] fetch_data,
	output logic bus_gnt_n,
	output logic burst_done,
	output logic bus_err
);
	logic [31:0] mem [logic [31:0]];
	logic done_sent;
	int fcnt;
	int bcnt;
	initial begin
		fetch_ack = 1'h0;
		fetch_err = 1'h0;
		fetch_data = 32'h0;
		bus_gnt_n = 1'h1;
		burst_done = 1'h0;
		bus_err = 1'h0;
		done_sent = 1'h0;
	end
	always @(negedge mclk) begin
		fetch_ack <= 1'h0;
		fetch_err <= 1'h0;
		burst_done <= 1'h0;
		// Junk between answers, so a stale word never passes for a fresh one
		fetch_data <= ~fetch_data;
		bus_err <= inj_berr;
		bus_gnt_n <= bus_req_n | !rst_n;
		if (!rst_n) begin
			fcnt = 0;
			bcnt = 0;
			done_sent <= 1'h0;
		end else begin
			if (fetch_req && !fetch_ack && !fetch_err) begin
				if (fcnt >= lag) begin
					fcnt = 0;
					fetch_ack <= !inj_ferr;
					fetch_err <= inj_ferr;
					fetch_data <= mem.exists(fetch_addr) ? mem[fetch_addr] : 32'h0;
				end else begin
					fcnt++;
				end
			end
			if (!burst_active) begin
				done_sent <= 1'h0;
			end else if (!done_sent) begin
				if (bcnt >= lag) begin
					bcnt = 0;
					burst_done <= 1'h1;
					done_sent <= 1'h1;
				end else begin
					bcnt++;
				end
			end
		end
	end
endmodule : bus_mem_model
`default_nettype wire

// ### tb_io_proc_fetch_block_move.sv
// Self-checking bench for the fetch and block move sequencer
`timescale 1ns/1ps
`default_nettype none
`include "io_fetch_consts.svh"
`define CHK(nm, ex, ac) begin checks_done++; if ((ac) !== (ex)) begin fail_count++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, ac); end end
module tb_io_proc_fetch_block_move;
	import io_fetch_pkg::*;
	logic mclk = 1'h0;
	logic rst_n = 1'h0, pp_wr = 1'h0, irq_serviced = 1'h0, fifo_ready = 1'h1;
	logic source_io_space_select = 1'h0, dest_io_space_select = 1'h0;
	logic [1:0] burst_size_sel = 2'h0;
	logic [31:0] pp_wdata = 32'h0;
	logic fetch_ack, fetch_err, bus_gnt_n, burst_done, bus_err;
	logic fetch_req, fetch_ram_sel, bus_req_n, burst_active, burst_to_mem, burst_io_space;
	logic host_irq, halted;
	logic [1:0] irq_cause;
	logic [7:0] burst_len, opcode_reg;
	logic [23:0] transfer_count_reg;
	logic [31:0] fetch_data, fetch_addr, burst_addr, program_ptr, second_word_reg;
	logic [31:0] next_data_address_reg, temp_shadow_reg;
	logic inj_ferr = 1'h0, inj_berr = 1'h0;
	logic [3:0] lag = 4'h0;
	logic [31:0] seed = 32'h1fb51db7;
	logic [31:0] exp_addr = 32'h0;
	logic [23:0] rem = 24'h0, blk = 24'h4;
	logic exp_dir = 1'h0, req_prev = 1'h1, fifo_prev = 1'h0, exp_space = 1'h0;
	int fail_count = 0, checks_done = 0, bursts = 0, fetches = 0;

	io_proc_fetch_block_move io_proc_fetch_block_move_inst (.mclk, .rst_n, .pp_wr, .pp_wdata,
		.irq_serviced, .source_io_space_select, .dest_io_space_select, .burst_size_sel,
		.fifo_ready, .fetch_ack, .fetch_err, .fetch_data, .bus_gnt_n, .burst_done, .bus_err,
		.fetch_req, .fetch_addr, .fetch_ram_sel, .bus_req_n, .burst_active, .burst_addr,
		.burst_len, .burst_to_mem, .burst_io_space, .host_irq, .halted, .irq_cause,
		.program_ptr, .opcode_reg, .transfer_count_reg, .second_word_reg,
		.next_data_address_reg, .temp_shadow_reg);
	bus_mem_model bus_mem_model_inst (.mclk, .rst_n, .fetch_req, .fetch_addr, .bus_req_n,
		.burst_active, .inj_ferr, .inj_berr, .lag, .fetch_ack, .fetch_err, .fetch_data,
		.bus_gnt_n, .burst_done, .bus_err);

	always #25 mclk = ~mclk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [31:0] mv_word(input logic ind, tbl, dir, input logic [23:0] cnt);
		return {2'h0, ind, tbl, 3'h0, dir, cnt};
	endfunction : mv_word

	function automatic logic [23:0] next_len(input logic [23:0] left, size);
		return (left < size) ? left : size;
	endfunction : next_len

	task automatic mem_w(input logic [31:0] a, w);
		bus_mem_model_inst.mem[a] = w;
	endtask : mem_w

	task automatic print_verdict();
		$display("Checks made %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	// Start at pc, run to the halt, then service and leave the block halted and quiet
	task automatic go(input logic [31:0] pc, input logic [1:0] cause);
		int t;
		@(negedge mclk);
		pp_wr = 1'h1;
		pp_wdata = pc;
		@(negedge mclk);
		pp_wr = 1'h0;
		t = 0;
		while (host_irq !== 1'h1 && t < 4000) begin
			@(negedge mclk);
			t++;
		end
		`CHK("irq_cause", cause, irq_cause)
		`CHK("halted", 1'h1, halted)
		repeat (4) @(negedge mclk);
		`CHK("halt_quiet", 2'h1, {fetch_req, bus_req_n})
		pp_wr = 1'h1;
		@(negedge mclk);
		pp_wr = 1'h0;
		irq_serviced = 1'h1;
		@(negedge mclk);
		irq_serviced = 1'h0;
		`CHK("refused_start", 1'h0, fetch_req)
		`CHK("irq_cleared", 1'h0, host_irq)
	endtask : go

	task automatic move(input logic [31:0] pc, data, input logic [23:0] cnt,
			input logic dir, ind, input logic [1:0] cause);
		mem_w(pc, mv_word(ind, 1'h0, dir, cnt));
		mem_w(pc + 32'h4, ind ? pc + 32'h80 : data);
		mem_w(pc + 32'h8, 32'h98000000 | {8'h0, cnt});
		mem_w(pc + 32'hC, pc);
		mem_w(pc + 32'h80, data);
		rem = cnt;
		exp_addr = data;
		exp_dir = dir;
		exp_space = dir ? dest_io_space_select : source_io_space_select;
		blk = 24'h4 << burst_size_sel;
		bursts = 0;
		fetches = 0;
		go(pc, cause);
		if (cause == CAUSE_INT) begin
			`CHK("count_left", 24'h0, rem)
			`CHK("burst_count", (cnt + blk - 24'h1) / blk, bursts)
			`CHK("fetch_words", ind ? 5 : 4, fetches)
			`CHK("prog_ptr", pc + 32'h10, program_ptr)
			`CHK("opcode", 8'h98, opcode_reg)
			`CHK("count_reg", cnt, transfer_count_reg)
			`CHK("second_word", pc, second_word_reg)
			`CHK("data_ptr", exp_addr, next_data_address_reg)
		end
	endtask : move

	always @(posedge mclk) begin
		if (rst_n) begin
			if (fetch_req && (fetch_ack || fetch_err)) begin
				fetches++;
				`CHK("fetch_align", 2'h0, fetch_addr[1:0])
				`CHK("ram_sel", (fetch_addr & `RAM_MASK) == `RAM_BASE, fetch_ram_sel)
			end
			if (burst_active && burst_done) begin
				`CHK("burst_addr", exp_addr, burst_addr)
				`CHK("burst_len", next_len(rem, blk), burst_len)
				`CHK("burst_dir", exp_dir, burst_to_mem)
				`CHK("burst_space", exp_space, burst_io_space)
				exp_addr += {8'h0, next_len(rem, blk)};
				rem -= next_len(rem, blk);
				bursts++;
			end
			if (req_prev && !bus_req_n) `CHK("fifo_gate", 1'h1, fifo_prev)
			req_prev = bus_req_n;
			fifo_prev = fifo_ready;
		end
	end

	// A starved FIFO now and then stretches the gaps between bursts
	always @(negedge mclk) if (rst_n) fifo_ready <= (rnd() & 32'h3) != 32'h0;

	initial begin
		logic [31:0] r;
		repeat (3) @(negedge mclk);
		rst_n = 1'h1;
		@(negedge mclk);
		`CHK("reset_req", 1'h1, bus_req_n)
		`CHK("reset_irq", 1'h0, host_irq)
		move(32'h100, 32'h2000, 24'h18, 1'h0, 1'h0, CAUSE_INT);
		burst_size_sel = 2'h3;
		move(32'h200, 32'h3001, 24'h45, 1'h1, 1'h1, CAUSE_INT);
		move(32'h300, 32'h0, 24'h0, 1'h0, 1'h0, CAUSE_INT);
		move(32'hFFFFF100, 32'h4000, 24'h9, 1'h1, 1'h0, CAUSE_INT);
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			burst_size_sel = r[1:0];
			source_io_space_select = r[2];
			dest_io_space_select = r[3];
			lag = {2'h0, r[5:4]};
			move(32'h1000 + 32'(i * 256), rnd(), {17'h0, r[12:6]}, r[13], r[14], CAUSE_INT);
		end
		lag = 4'h0;
		inj_berr = 1'h1;
		move(32'h400, 32'h5000, 24'h10, 1'h0, 1'h0, CAUSE_ERR);
		inj_berr = 1'h0;
		inj_ferr = 1'h1;
		go(32'h500, CAUSE_ERR);
		inj_ferr = 1'h0;
		go(32'h602, CAUSE_ILLEGAL);
		mem_w(32'h700, mv_word(1'h0, 1'h1, 1'h0, 24'h8));
		go(32'h700, CAUSE_ILLEGAL);
		mem_w(32'h800, 32'h40000000);
		go(32'h800, CAUSE_ILLEGAL);
		mem_w(32'h900, 32'hC0000010);
		mem_w(32'h908, 32'hA5A50F0F);
		go(32'h900, CAUSE_ILLEGAL);
		`CHK("shadow_word", 32'hA5A50F0F, temp_shadow_reg)
		`CHK("prog_ptr_long", 32'h90C, program_ptr)
		print_verdict();
	end

	initial begin
		repeat (80000) @(posedge mclk);
		fail_count++;
		$display("[ERR] watchdog expected finish seen hang");
		print_verdict();
	end
endmodule : tb_io_proc_fetch_block_move
`default_nettype wire
